// File: src/dcu_pkg.sv
// Summary of operation
// - Each data bit sent twice, second inverted
// - Character is start, eight data, parity, two stops
// - Data bits go least significant first
// - Parity bit makes even count of ones
// - Each byte travels as two nibble characters
// - Coded nibble fills eight data bit positions
// - Message: preamble, data characters, optional stop
// - Preamble is uncoded 15h
// - Imperfect preamble is taken as data character
// - Transmitter frames and codes messages by itself
// - Bit rate 0.5, 1, 2 or 4 Mbps
// - No-preamble mode drops leading preamble
// - No-stop mode drops trailing stop character
// - Raw transmit mode sends bytes uncoded
// - Raw receive mode skips Manchester decoding
// - Read replies may carry data-check byte
// - Messages carry CRC-8 packet check byte
// - Messages may end with alive-count byte
// - Keep-alive characters sent at programmed interval
// - Only host starts transfers, chain returns data
// - Stop character is uncoded 54h
// - Coded data characters carry parity zero
package dcu_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int RATE_UNIT_HZ = 500_000;
    localparam logic [6:0] ACC_MOD = 7'(CLK_HZ / RATE_UNIT_HZ);
    localparam logic [6:0] ACC_HALF = 7'(CLK_HZ / RATE_UNIT_HZ / 2);
    localparam logic [5:0] US_CYC = 6'(CLK_HZ / 1_000_000);
    localparam logic [3:0] CHAR_BITS = 4'hC;
    localparam logic [3:0] RX_LAST = 4'hA;

    // ----------------------------------------
    // Register map and fields
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_KA_PERIOD = 8'h04;
    localparam logic [7:0] OFF_TXDATA = 8'h08;
    localparam logic [7:0] OFF_RXDATA = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_RX_PEC = 8'h14;
    localparam int CTL_RATE = 0;
    localparam int CTL_NO_PRE = 2;
    localparam int CTL_NO_STOP = 3;
    localparam int CTL_RAW_TX = 4;
    localparam int CTL_RAW_RX = 5;
    localparam int CTL_KA_EN = 6;
    localparam int TXD_LAST = 8;
    localparam int ST_STK = 3;
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [15:0] KA_PERIOD_RST = 16'h03E8;

    // ----------------------------------------
    // Link characters
    // ----------------------------------------
    localparam logic [7:0] CHAR_PRE = 8'h15;
    localparam logic [7:0] CHAR_STOP = 8'h54;
    localparam logic [7:0] CHAR_KA = 8'h54;
    localparam logic [7:0] CRC_POLY = 8'hA6;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_PRE = 3'h1,
        TX_LO = 3'h3,
        TX_HI = 3'h2,
        TX_STOP = 3'h6,
        TX_KA = 3'h4
    } dcu_tx_st_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } dcu_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } dcu_ahb_rsp_t;

endpackage

// File: src/dcu_framer.sv
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module dcu_framer
    import dcu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire dcu_ahb_req_t ahb_req,
    output var dcu_ahb_rsp_t ahb_rsp,
    input wire logic uart_rx_pin,
    output var logic uart_tx_pin
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Fractional divider: exact average rate at 12.5 cycles per bit
    function automatic logic [7:0] acc_step(input logic [6:0] a, input logic [6:0] inc);
        logic [7:0] s;
        s = {1'b0, a} + {1'b0, inc};
        if (s >= {1'b0, ACC_MOD}) begin
            acc_step = {1'b1, 7'(s - {1'b0, ACC_MOD})};
        end else begin
            acc_step = {1'b0, s[6:0]};
        end
    endfunction

    function automatic logic [11:0] mk_frame(input logic [7:0] d);
        mk_frame = {2'b11, ^d, d, 1'b0};
    endfunction

    function automatic logic [7:0] man_enc(input logic [3:0] n);
        man_enc = {~n[3], n[3], ~n[2], n[2], ~n[1], n[1], ~n[0], n[0]};
    endfunction

    function automatic logic man_ok(input logic [7:0] d);
        man_ok = (d[1] ^ d[0]) & (d[3] ^ d[2]) & (d[5] ^ d[4])
            & (d[7] ^ d[6]);
    endfunction

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        crc8 = r;
    endfunction

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic [6:0] ctrl_q;
    logic [15:0] ka_per_q;
    logic wr_pend_q;
    logic [7:0] wr_off_q;
    dcu_ahb_rsp_t rsp_q;
    logic [31:0] rdata_w;
    logic [31:0] status_w;
    logic [5:0] stk_q;
    logic [5:0] stk_set;
    logic pec_ok_q;
    logic [7:0] crc_q;
    logic [7:0] rx_byte_q;
    logic rx_v_q;
    logic hold_v_q;
    logic [8:0] hold_q;
    logic tx_busy;

    wire logic acc_go = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
    wire logic [7:0] a_off = ahb_req.haddr[7:0];
    wire logic rd_go = acc_go & ~ahb_req.hwrite;
    wire logic wr_go = acc_go & ahb_req.hwrite;
    wire logic rx_pop = rd_go & (a_off == OFF_RXDATA);
    wire logic [31:0] wdata = ahb_req.hwdata;
    wire logic wr_ctrl = wr_pend_q & (wr_off_q == OFF_CTRL);
    wire logic wr_kap = wr_pend_q & (wr_off_q == OFF_KA_PERIOD);
    wire logic wr_txd = wr_pend_q & (wr_off_q == OFF_TXDATA);
    wire logic wr_stat = wr_pend_q & (wr_off_q == OFF_STATUS);
    wire logic [6:0] rate_inc = 7'h01 << ctrl_q[CTL_RATE +: 2];
    wire logic no_pre = ctrl_q[CTL_NO_PRE];
    wire logic no_stop = ctrl_q[CTL_NO_STOP];
    wire logic raw_tx = ctrl_q[CTL_RAW_TX];
    wire logic raw_rx = ctrl_q[CTL_RAW_RX];
    wire logic ka_en = ctrl_q[CTL_KA_EN];

    assign status_w = {22'h0, pec_ok_q, stk_q, rx_v_q, hold_v_q, tx_busy};

    always_comb begin
        case (a_off)
            OFF_CTRL: rdata_w = {25'h0, ctrl_q};
            OFF_KA_PERIOD: rdata_w = {16'h0, ka_per_q};
            OFF_RXDATA: rdata_w = {23'h0, rx_v_q, rx_byte_q};
            OFF_STATUS: rdata_w = status_w;
            OFF_RX_PEC: rdata_w = {24'h0, crc_q};
            default: rdata_w = 32'h0;
        endcase
    end

    // Single-cycle data phase; every answer is OKAY
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_q <= '{hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0};
            wr_pend_q <= 1'b0;
            wr_off_q <= 8'h00;
        end else begin
            wr_pend_q <= wr_go;
            if (acc_go) begin
                wr_off_q <= a_off;
            end
            if (rd_go) begin
                rsp_q.hrdata <= rdata_w;
            end
        end
    end

    assign ahb_rsp = rsp_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= CTRL_RST;
            ka_per_q <= KA_PERIOD_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wdata[6:0];
            end
            if (wr_kap) begin
                ka_per_q <= wdata[15:0];
            end
        end
    end

    // Write-one-to-clear; a new event in the same cycle stays set
    wire logic [5:0] stk_clr = wr_stat ? wdata[ST_STK +: 6] : 6'h00;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stk_q <= 6'h00;
        end else begin
            stk_q <= (stk_q & ~stk_clr) | stk_set;
        end
    end

    // ----------------------------------------
    // Transmit holding register
    // ----------------------------------------
    logic take;
    wire logic hold_ld = wr_txd & (~hold_v_q | take);
    wire logic tx_ovr = wr_txd & hold_v_q & ~take;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_v_q <= 1'b0;
            hold_q <= 9'h000;
        end else begin
            hold_v_q <= hold_ld | (hold_v_q & ~take);
            if (hold_ld) begin
                hold_q <= wdata[8:0];
            end
        end
    end

    // ----------------------------------------
    // Transmit sequencer
    // ----------------------------------------
    dcu_tx_st_t st_q, st_d;
    logic [6:0] tx_acc_q;
    logic [3:0] tx_cnt_q;
    logic [10:0] tsh_q;
    logic [7:0] cur_q;
    logic cur_last_q;
    logic ka_due_q;
    logic ld;
    logic ka_clr;
    logic [7:0] chr;

    wire logic [7:0] tx_step = acc_step(tx_acc_q, rate_inc);
    wire logic tx_tick = tx_step[7];
    wire logic bnd = tx_tick & (tx_cnt_q <= 4'h1);
    wire logic [7:0] hold_chr = raw_tx ? hold_q[7:0] : man_enc(hold_q[3:0]);
    wire dcu_tx_st_t hold_st = raw_tx ? TX_HI : TX_LO;
    wire logic [11:0] frame = mk_frame(chr);

    assign tx_busy = (st_q != TX_IDLE) | (tx_cnt_q != 4'h0);

    always_comb begin
        st_d = st_q;
        ld = 1'b0;
        take = 1'b0;
        ka_clr = 1'b0;
        chr = 8'h00;
        if (bnd) begin
            case (st_q)
                TX_IDLE: begin
                    if (hold_v_q && no_pre) begin
                        take = 1'b1;
                        ld = 1'b1;
                        chr = hold_chr;
                        st_d = hold_st;
                    end else if (hold_v_q) begin
                        ld = 1'b1;
                        chr = CHAR_PRE;
                        st_d = TX_PRE;
                    end else if (ka_due_q) begin
                        ld = 1'b1;
                        ka_clr = 1'b1;
                        chr = CHAR_KA;
                        st_d = TX_KA;
                    end
                end
                TX_PRE: begin
                    take = 1'b1;
                    ld = 1'b1;
                    chr = hold_chr;
                    st_d = hold_st;
                end
                TX_LO: begin
                    ld = 1'b1;
                    chr = man_enc(cur_q[7:4]);
                    st_d = TX_HI;
                end
                TX_HI: begin
                    if (cur_last_q && no_stop) begin
                        st_d = TX_IDLE;
                    end else if (cur_last_q) begin
                        ld = 1'b1;
                        chr = CHAR_STOP;
                        st_d = TX_STOP;
                    end else if (hold_v_q) begin
                        take = 1'b1;
                        ld = 1'b1;
                        chr = hold_chr;
                        st_d = hold_st;
                    end
                end
                TX_STOP, TX_KA: st_d = TX_IDLE;
                default: st_d = TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= TX_IDLE;
            cur_q <= 8'h00;
            cur_last_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (take) begin
                cur_q <= hold_q[7:0];
                cur_last_q <= hold_q[TXD_LAST];
            end
        end
    end

    // Serialiser: start bit first, line idles high
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_acc_q <= 7'h00;
            tx_cnt_q <= 4'h0;
            tsh_q <= 11'h7FF;
            uart_tx_pin <= 1'b1;
        end else begin
            tx_acc_q <= tx_step[6:0];
            if (ld) begin
                uart_tx_pin <= frame[0];
                tsh_q <= frame[11:1];
                tx_cnt_q <= CHAR_BITS;
            end else if (tx_tick && tx_cnt_q > 4'h1) begin
                uart_tx_pin <= tsh_q[0];
                tsh_q <= {1'b1, tsh_q[10:1]};
                tx_cnt_q <= tx_cnt_q - 4'h1;
            end else if (tx_tick) begin
                uart_tx_pin <= 1'b1;
                tx_cnt_q <= 4'h0;
            end
        end
    end

    // ----------------------------------------
    // Keep-alive timer
    // ----------------------------------------
    // Counts only while the link is quiet, so traffic defers the next character
    logic [5:0] us_cnt_q;
    logic [15:0] ka_cnt_q;
    wire logic us_tick = (us_cnt_q == US_CYC - 6'h01);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            us_cnt_q <= 6'h00;
            ka_cnt_q <= 16'h0000;
            ka_due_q <= 1'b0;
        end else begin
            us_cnt_q <= us_tick ? 6'h00 : us_cnt_q + 6'h01;
            if (!ka_en || ka_clr) begin
                ka_due_q <= 1'b0;
            end
            if (!ka_en || tx_busy || ka_due_q) begin
                ka_cnt_q <= 16'h0000;
            end else if (us_tick && (ka_cnt_q + 16'h0001 >= ka_per_q)) begin
                ka_cnt_q <= 16'h0000;
                ka_due_q <= 1'b1;
            end else if (us_tick) begin
                ka_cnt_q <= ka_cnt_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // Receive sampler
    // ----------------------------------------
    logic rx_s1_q, rx_s2_q, rx_s3_q;
    logic rx_act_q;
    logic [6:0] rx_acc_q;
    logic [3:0] rx_n_q;
    logic [10:0] rsh_q;
    logic chr_v_q;
    wire logic [7:0] rx_step = acc_step(rx_acc_q, rate_inc);
    wire logic rx_fall = rx_s3_q & ~rx_s2_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
        end else begin
            rx_s1_q <= uart_rx_pin;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
        end
    end

    // Sampling starts half a bit after the start edge; second stop bit is not checked
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_act_q <= 1'b0;
            rx_acc_q <= 7'h00;
            rx_n_q <= 4'h0;
            rsh_q <= 11'h000;
            chr_v_q <= 1'b0;
        end else begin
            chr_v_q <= 1'b0;
            if (!rx_act_q) begin
                if (rx_fall) begin
                    rx_act_q <= 1'b1;
                    rx_acc_q <= ACC_HALF;
                    rx_n_q <= 4'h0;
                end
            end else begin
                rx_acc_q <= rx_step[6:0];
                if (rx_step[7]) begin
                    rsh_q <= {rx_s2_q, rsh_q[10:1]};
                    rx_n_q <= rx_n_q + 4'h1;
                    if (rx_n_q == 4'h0 && rx_s2_q) begin
                        rx_act_q <= 1'b0;
                    end else if (rx_n_q == RX_LAST) begin
                        rx_act_q <= 1'b0;
                        chr_v_q <= 1'b1;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Receive decoder
    // ----------------------------------------
    logic half_q;
    logic [3:0] lo_q;
    wire logic [7:0] rd8 = rsh_q[8:1];
    wire logic rpar = rsh_q[9];
    wire logic par_ok = ~^{rd8, rpar};
    wire logic is_pre = chr_v_q & ({rpar, rd8} == {^CHAR_PRE, CHAR_PRE});
    wire logic is_stp = chr_v_q & ({rpar, rd8} == {^CHAR_STOP, CHAR_STOP});
    wire logic is_dat = chr_v_q & ~is_pre & ~is_stp;
    wire logic m_ok = man_ok(rd8);
    wire logic [3:0] nib = {rd8[6], rd8[4], rd8[2], rd8[0]};
    wire logic push = is_dat & (raw_rx | half_q);
    wire logic [7:0] rx_byte_d = raw_rx ? rd8 : {nib, lo_q};

    // Sticky order: manchester, parity, framing, rx overrun, tx overrun, stop seen
    assign stk_set = {is_stp, tx_ovr, push & rx_v_q & ~rx_pop,
        chr_v_q & ~rsh_q[10], is_dat & ~par_ok, is_dat & ~raw_rx & ~m_ok};

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            half_q <= 1'b0;
            lo_q <= 4'h0;
            crc_q <= 8'h00;
            pec_ok_q <= 1'b0;
            rx_v_q <= 1'b0;
            rx_byte_q <= 8'h00;
        end else begin
            rx_v_q <= push | (rx_v_q & ~rx_pop);
            if (is_pre) begin
                half_q <= 1'b0;
                crc_q <= 8'h00;
            end else if (is_dat && !raw_rx) begin
                half_q <= ~half_q;
                if (!half_q) begin
                    lo_q <= nib;
                end
            end
            if (push) begin
                rx_byte_q <= rx_byte_d;
                crc_q <= crc8(crc_q, rx_byte_d);
            end
            if (is_stp) begin
                pec_ok_q <= (crc_q == 8'h00) & ~half_q;
            end
        end
    end

endmodule
`default_nettype wire

// File: bench/dcu_framer_sva.sv
`timescale 1ns/1ns
`default_nettype none
module dcu_framer_sva
    import dcu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire dcu_ahb_req_t ahb_req,
    input wire dcu_ahb_rsp_t ahb_rsp,
    input wire logic uart_rx_pin,
    input wire logic uart_tx_pin
);
    // ----------------------------------------
    // Shadow of host register writes
    // ----------------------------------------
    logic take;
    logic wr_pend_q;
    logic [7:0] wr_off_q;
    logic [6:0] ctrl_q;
    logic [15:0] ka_q;
    assign take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_q <= 1'b0;
            wr_off_q <= 8'h00;
            ctrl_q <= CTRL_RST;
            ka_q <= KA_PERIOD_RST;
        end else begin
            wr_pend_q <= take && ahb_req.hwrite;
            wr_off_q <= ahb_req.haddr[7:0];
            if (wr_pend_q && wr_off_q == OFF_CTRL) ctrl_q <= ahb_req.hwdata[6:0];
            if (wr_pend_q && wr_off_q == OFF_KA_PERIOD) ka_q <= ahb_req.hwdata[15:0];
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence rd_take(logic [7:0] off);
        take && !ahb_req.hwrite && ahb_req.haddr[7:0] == off;
    endsequence
    sequence rd_dead;
        take && !ahb_req.hwrite && (ahb_req.haddr[7:0] == OFF_TXDATA || ahb_req.haddr[7:0] > 8'h14);
    endsequence
    a_resp_okay: assert property (!ahb_rsp.hresp && ahb_rsp.hreadyout)
        else $error("bus response not OKAY or not ready");
    a_idle_after_reset: assert property ($rose(rst_b) |-> uart_tx_pin && ahb_rsp.hrdata == 32'h0)
        else $error("link or read data not idle after reset");
    a_bit_min_width: assert property ($changed(uart_tx_pin) |=> $stable(uart_tx_pin) [*8])
        else $error("link bit shorter than fastest rate");
    a_low_run_bound: assert property ($fell(uart_tx_pin) |-> ##[1:1000] uart_tx_pin)
        else $error("link low longer than a character body");
    a_unmapped_zero: assert property (rd_dead |=> ahb_rsp.hrdata == 32'h0)
        else $error("unmapped or write-only read not zero");
    a_ctrl_readback: assert property (rd_take(OFF_CTRL) |=> ahb_rsp.hrdata == {25'h0, $past(ctrl_q)})
        else $error("control readback differs");
    a_ka_readback: assert property (rd_take(OFF_KA_PERIOD) |=> ahb_rsp.hrdata == {16'h0, $past(ka_q)})
        else $error("keep-alive interval readback differs");
    a_rdata_stands: assert property (!take || ahb_req.hwrite |=> $stable(ahb_rsp.hrdata))
        else $error("read data moved without a read");
endmodule
bind dcu_framer dcu_framer_sva i_sva (.core_clk(core_clk), .rst_b(rst_b), .ahb_req(ahb_req),
    .ahb_rsp(ahb_rsp), .uart_rx_pin(uart_rx_pin), .uart_tx_pin(uart_tx_pin));
`default_nettype wire

// File: bench/dcu_chain_model.sv
`timescale 1ns/1ns
`default_nettype none
module dcu_chain_model (
    input wire logic core_clk,
    input wire logic tx_line,
    output var logic rx_line,
    input wire logic [1:0] rate
);
    // ----------------------------------------
    // Chain device: receive then echo back down
    // ----------------------------------------
    logic [11:0] got_q[$];
    logic [11:0] send_q[$];
    logic busy = 1'b0;
    // Fractional timing so the 12.5 cycle bit of the fastest rate does not drift
    initial begin
        logic [11:0] ch;
        int c;
        int k;
        forever begin
            @(negedge tx_line);
            c = 0;
            k = 0;
            while (k < 12) begin
                @(posedge core_clk);
                c++;
                if (c * (1 << rate) >= (2 * k + 1) * 50) begin
                    ch[k] = tx_line;
                    k++;
                end
            end
            got_q.push_back(ch);
            send_q.push_back(ch);
        end
    end
    // Bit 12 is one idle bit kept high before the next character
    initial begin
        logic [12:0] ch;
        int c;
        rx_line = 1'b1;
        forever begin
            @(posedge core_clk);
            if (send_q.size() != 0) begin
                busy = 1'b1;
                ch = {1'b1, send_q.pop_front()};
                c = 0;
                for (int k = 0; k < 13; k++) begin
                    rx_line <= ch[k];
                    while (c * (1 << rate) < (k + 1) * 100) begin
                        @(posedge core_clk);
                        c++;
                    end
                end
                busy = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
    import dcu_pkg::*;
;
    // ----------------------------------------
    // Harness
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] link_rate = 2'h0;
    dcu_ahb_req_t mreq = '0;
    dcu_ahb_req_t req_w;
    dcu_ahb_rsp_t rsp;
    wire logic tx_w;
    wire logic rx_w;
    int bad_count = 0;
    int n_checks = 0;
    logic [31:0] rd;
    logic [7:0] crc;
    logic [11:0] exp_q[$];
    logic [6:0] ctl_tab[4] = '{7'h00, 7'h05, 7'h0A, 7'h33};
    logic [7:0] byte_tab[4] = '{8'hA5, 8'h3C, 8'hF0, 8'h81};
    always #10 core_clk = ~core_clk;
    always_comb begin
        req_w = mreq;
        req_w.hready = rsp.hreadyout;
    end
    dcu_framer i_dut (.core_clk(core_clk), .rst_b(rst_b), .ahb_req(req_w), .ahb_rsp(rsp),
        .uart_rx_pin(rx_w), .uart_tx_pin(tx_w));
    dcu_chain_model i_chain (.core_clk(core_clk), .tx_line(tx_w), .rx_line(rx_w),
        .rate(link_rate));
    function automatic logic [11:0] chr(input logic [7:0] d);
        return {2'b11, ^d, d, 1'b0};
    endfunction
    function automatic logic [7:0] man(input logic [3:0] n);
        return {~n[3], n[3], ~n[2], n[2], ~n[1], n[1], ~n[0], n[0]};
    endfunction
    function automatic logic [7:0] crc8(input logic [7:0] d);
        logic [7:0] c;
        c = d;
        for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
        return c;
    endfunction
    // ----------------------------------------
    // Reporting and bus tasks
    // ----------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic tick(inout int n, input int lim);
        @(posedge core_clk);
        n++;
        if (n > lim) begin
            $display("ERROR t=%0t timeout got=%h exp=%h", $time, n, lim);
            bad_count++;
            close_out();
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] off, input logic [31:0] wd,
        output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge core_clk);
        mreq <= '{1'b1, {24'h0, off}, 2'b10, w, 3'h2, mreq.hwdata, 1'b0};
        do tick(n, 50); while (rsp.hreadyout !== 1'b1);
        mreq.hsel <= 1'b0;
        mreq.htrans <= 2'b00;
        mreq.hwdata <= wd;
        do tick(n, 100); while (rsp.hreadyout !== 1'b1);
        rdat = rsp.hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] off, input logic [31:0] mask, input logic [31:0] exp);
        ahb(1'b0, off, 32'h0, rd);
        chk(rd & mask, exp);
    endtask
    // Holding register is polled first so no byte is dropped as overrun
    task automatic put(input logic [8:0] b);
        int n;
        n = 0;
        do begin
            ahb(1'b0, OFF_STATUS, 32'h0, rd);
            tick(n, 5000);
        end while (rd[1] !== 1'b0);
        ahb(1'b1, OFF_TXDATA, {23'h0, b}, rd);
    endtask
    task automatic quiet();
        int n;
        n = 0;
        do tick(n, 20000); while (i_chain.send_q.size() != 0 || i_chain.busy);
    endtask
    task automatic wait_chars(input int k);
        int n;
        n = 0;
        while (i_chain.got_q.size() < k) tick(n, 30000);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        rd_chk(OFF_CTRL, 32'hFFFFFFFF, 32'h0);
        rd_chk(OFF_KA_PERIOD, 32'hFFFFFFFF, 32'h3E8);
        rd_chk(OFF_TXDATA, 32'hFFFFFFFF, 32'h0);
        rd_chk(8'h18, 32'hFFFFFFFF, 32'h0);
        ahb(1'b1, OFF_KA_PERIOD, 32'h1234, rd);
        rd_chk(OFF_KA_PERIOD, 32'hFFFFFFFF, 32'h1234);
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, OFF_CTRL, {25'h0, ctl_tab[i]}, rd);
            rd_chk(OFF_CTRL, 32'hFFFFFFFF, {25'h0, ctl_tab[i]});
            link_rate <= ctl_tab[i][1:0];
            i_chain.got_q.delete();
            exp_q.delete();
            if (!ctl_tab[i][2]) exp_q.push_back(chr(CHAR_PRE));
            if (ctl_tab[i][4]) exp_q.push_back(chr(byte_tab[i]));
            else exp_q.push_back(chr(man(byte_tab[i][3:0])));
            if (!ctl_tab[i][4]) exp_q.push_back(chr(man(byte_tab[i][7:4])));
            if (!ctl_tab[i][3]) exp_q.push_back(chr(CHAR_STOP));
            put({1'b1, byte_tab[i]});
            wait_chars(exp_q.size());
            foreach (exp_q[j]) chk({20'h0, i_chain.got_q[j]}, {20'h0, exp_q[j]});
            quiet();
            chk(32'(i_chain.got_q.size()), 32'(exp_q.size()));
            rd_chk(OFF_RXDATA, 32'h1FF, {24'h1, byte_tab[i]});
        end
        ahb(1'b1, OFF_CTRL, 32'h0, rd);
        link_rate <= 2'h0;
        ahb(1'b1, OFF_STATUS, 32'h3F8, rd);
        i_chain.got_q.delete();
        crc = crc8(8'h5A);
        put({1'b0, 8'h5A});
        put({1'b1, crc});
        wait_chars(6);
        quiet();
        chk(32'(i_chain.got_q.size()), 32'h6);
        rd_chk(OFF_STATUS, 32'h3B8, 32'h300);
        rd_chk(OFF_RX_PEC, 32'hFF, 32'h0);
        ahb(1'b1, OFF_STATUS, 32'h3F8, rd);
        rd_chk(OFF_STATUS, 32'h108, 32'h0);
        i_chain.send_q.push_back(chr(8'h00));
        quiet();
        rd_chk(OFF_STATUS, 32'h8, 32'h8);
        ahb(1'b1, OFF_KA_PERIOD, 32'h2, rd);
        i_chain.got_q.delete();
        ahb(1'b1, OFF_CTRL, 32'h40, rd);
        wait_chars(2);
        chk({20'h0, i_chain.got_q[0]}, {20'h0, chr(CHAR_KA)});
        chk({20'h0, i_chain.got_q[1]}, {20'h0, chr(CHAR_KA)});
        ahb(1'b1, OFF_CTRL, 32'h0, rd);
        ahb(1'b1, OFF_TXDATA, 32'h0, rd);
        ahb(1'b1, OFF_TXDATA, 32'h0, rd);
        rd_chk(OFF_STATUS, 32'h82, 32'h82);
        close_out();
    end
endmodule
`default_nettype wire
